// File: verilog/abs_serial.v
// Purpose: Auto-buffered three-wire serial unit with APB register access
// Assumes: Single clock pclk at 250 MHz, external serial clock synchronised
// Notes:   Slave serial clock must be well below pclk/4
//
// What this block does
// - Eight-bit transfers over clock, in, out lines
// - Bit order selectable, MSB or LSB first
// - Thirty-two byte buffer RAM for auto transfers
// - Master rate up to about 10.4 Mbps (250 MHz, prescale 4, ratio 6)
// - Master or slave serial clock selectable
// - Auto run length one to thirty-two bytes
// - Auto inter-byte gap zero to 63 clocks
// - Auto single run or continuous repeat
// - Baud divider ratios 6, 8, 16, 32
// - Completion interrupt output when transfer finishes
// - Shift byte holds data in single mode
// - Writing shift byte in single mode starts one transfer
// - Read shift byte after done gives received data
// - Shift byte whole-byte access, resets zero
// - Address counter tracks buffer position, readable
// - Address counter read-only, zero reset, idle read
// - RAM as sixteen halfword locations, byte lanes
// - Enable clear resets unit, out low, clock high
// - Repeat run clears counter and restarts
// - Active flag high only during transfer
// - Transmit disabled holds data out low
`timescale 1ns/100ps
`include "abs_defines.vh"

module abs_serial
#(
    parameter RAM_BYTES = 32,                 // Buffer RAM size
    parameter BRG_PRESC = `ABS_BRG_PRESC      // Prescale before divider
)
(
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Serial pins
    input  wire        serial_clock_pin_i,
    output wire        serial_clock_pin_o,
    output wire        serial_clock_pin_oe_n,
    input  wire        serial_in_pin,
    output wire        serial_out_pin,
    // Interrupt
    output wire        transfer_done_irq
);

    // ======================================================================
    // Registers and state
    reg  [7:0]  mode_control_reg_ff;          // Mode bits
    reg  [1:0]  divisor_select_ff;            // Ratio 6/8/16/32
    reg  [4:0]  auto_end_pointer_ff;          // Last buffer index
    reg  [5:0]  auto_interval_setting_ff;     // Gap in pclk cycles
    reg  [7:0]  serial_shift_byte_ff;         // Shift register
    reg  [7:0]  buffer_address_counter_ff;    // Buffer position
    reg         transfer_active_flag_ff;      // Busy
    reg         done_ff;                      // Sticky completion
    reg  [7:0]  ram_ff [0:RAM_BYTES-1];       // Buffer RAM
    reg  [2:0]  bit_cnt_ff;                   // Bits left minus one
    reg  [2:0]  state_ff;                     // One-hot machine
    reg  [5:0]  gap_cnt_ff;                   // Gap counter
    reg  [7:0]  pre_cnt_ff;                   // Prescaler
    reg  [4:0]  div_cnt_ff;                   // Half-period counter
    reg         sck_ff;                       // Master clock level
    reg         sout_ff;                      // Output data bit
    reg  [2:0]  sck_sync_ff;                  // Slave clock sync
    reg  [1:0]  sin_sync_ff;                  // Data in sync
    reg         stop_req_ff;                  // Suspend pending
    integer     i;

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SHIFT = 3'b010;
    localparam [2:0] ST_GAP  = 3'b100;

    wire en        = mode_control_reg_ff[`ABS_MODE_ENABLE];
    wire auto_md   = mode_control_reg_ff[`ABS_MODE_AUTO];
    wire repeat_md = mode_control_reg_ff[`ABS_MODE_REPEAT];
    wire master    = mode_control_reg_ff[`ABS_MODE_MASTER];
    wire txen      = mode_control_reg_ff[`ABS_MODE_TXEN];
    wire rxen      = mode_control_reg_ff[`ABS_MODE_RXEN];
    wire lsbf      = mode_control_reg_ff[`ABS_MODE_LSBF];

    // ======================================================================
    // Helpers
    // Half period in prescaled ticks for ratio code
    function [4:0] half_div;
        input [1:0] sel;
        begin
            case (sel)
                2'd0:    half_div = 5'd3;
                2'd1:    half_div = 5'd4;
                2'd2:    half_div = 5'd8;
                default: half_div = 5'd16;
            endcase
        end
    endfunction

    // Bit to send next given order
    function out_bit;
        input [7:0] b;
        input       lsb;
        begin
            out_bit = lsb ? b[0] : b[7];
        end
    endfunction

    // ======================================================================
    // APB decode: zero wait states
    wire acc  = psel & penable;
    wire wr   = acc & pwrite;
    wire is_ram = (paddr >= `ABS_OFF_RAM_BASE) && (paddr <= `ABS_OFF_RAM_LAST);
    wire [3:0] ram_idx = paddr[5:2];
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // Read mux, unmapped reads return zero
    always @*
    begin
        prdata = 32'h0000_0000;
        if (paddr == `ABS_OFF_MODE)
            prdata[7:0] = mode_control_reg_ff;
        else if (paddr == `ABS_OFF_STATUS)
            prdata[7:0] = {divisor_select_ff, 4'h0, done_ff, transfer_active_flag_ff};
        else if (paddr == `ABS_OFF_DIVISOR)
            prdata[7:0] = {6'h00, divisor_select_ff};
        else if (paddr == `ABS_OFF_ENDPTR)
            prdata[7:0] = {3'h0, auto_end_pointer_ff};
        else if (paddr == `ABS_OFF_INTERVAL)
            prdata[7:0] = {2'h0, auto_interval_setting_ff};
        else if (paddr == `ABS_OFF_SHIFT)
            prdata[7:0] = serial_shift_byte_ff;
        else if (paddr == `ABS_OFF_ADDRCNT)
            prdata[7:0] = buffer_address_counter_ff;
        else if (is_ram && en)
            prdata[15:0] = {ram_ff[{ram_idx, 1'b1}], ram_ff[{ram_idx, 1'b0}]};
    end

    // ======================================================================
    // Serial clock generation and synchronisers
    wire tick = (pre_cnt_ff == BRG_PRESC[7:0] - 8'h01) &&
                (div_cnt_ff == half_div(divisor_select_ff) - 5'd1);
    wire sck_s = sck_sync_ff[1];
    wire slv_fall = sck_sync_ff[2] & ~sck_s;
    wire slv_rise = ~sck_sync_ff[2] & sck_s;
    wire shifting = (state_ff == ST_SHIFT);
    // Drive edge and sample edge, master or slave
    wire m_fall = master & tick & sck_ff & shifting;
    wire m_rise = master & tick & ~sck_ff & shifting;
    wire do_drive  = master ? m_fall : (slv_fall & shifting);
    wire do_sample = master ? m_rise : (slv_rise & shifting);
    wire sin_s = rxen & sin_sync_ff[1];                    // Reception off reads zero

    assign serial_clock_pin_o    = (master & en) ? sck_ff : 1'b1;
    assign serial_clock_pin_oe_n = ~(master | ~en);
    assign serial_out_pin        = en & txen & sout_ff;
    assign transfer_done_irq     = done_ff;

    // ======================================================================
    // Main sequential logic
    wire start_single = wr && (paddr == `ABS_OFF_SHIFT) && !auto_md;
    wire start_auto = wr && (paddr == `ABS_OFF_TRIGGER) && auto_md &&
                      pwdata[`ABS_TRIG_START];
    wire last_auto  = (buffer_address_counter_ff[4:0] == auto_end_pointer_ff);
    wire [7:0] rx_byte = lsbf ? {sin_s, serial_shift_byte_ff[7:1]}
                              : {serial_shift_byte_ff[6:0], sin_s};
    wire [4:0] cur = buffer_address_counter_ff[4:0];

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_control_reg_ff       <= `ABS_RST_BYTE;
            divisor_select_ff         <= 2'd0;
            auto_end_pointer_ff       <= 5'd0;
            auto_interval_setting_ff  <= 6'd0;
            serial_shift_byte_ff      <= `ABS_RST_BYTE;
            buffer_address_counter_ff <= `ABS_RST_BYTE;
            transfer_active_flag_ff   <= 1'b0;
            done_ff                   <= 1'b0;
            bit_cnt_ff                <= 3'd0;
            state_ff                  <= ST_IDLE;
            gap_cnt_ff                <= 6'd0;
            pre_cnt_ff                <= 8'h00;
            div_cnt_ff                <= 5'd0;
            sck_ff                    <= 1'b1;
            sout_ff                   <= 1'b0;
            sck_sync_ff               <= 3'b111;
            sin_sync_ff               <= 2'b00;
            stop_req_ff               <= 1'b0;
            for (i = 0; i < RAM_BYTES; i = i + 1)
                ram_ff[i] <= 8'h00;
        end
        else
        begin
            // Pin synchronisers: first stage feeds only second
            sck_sync_ff <= {sck_sync_ff[1], sck_sync_ff[0], serial_clock_pin_i};
            sin_sync_ff <= {sin_sync_ff[0], serial_in_pin};

            // Register writes; mode bit 0 always reads zero
            if (wr && paddr == `ABS_OFF_MODE)
                mode_control_reg_ff <= {pwdata[7:1], 1'b0};
            if (wr && paddr == `ABS_OFF_DIVISOR && !transfer_active_flag_ff)
                divisor_select_ff <= pwdata[1:0];
            if (wr && paddr == `ABS_OFF_ENDPTR && !transfer_active_flag_ff)
                auto_end_pointer_ff <= pwdata[4:0];
            if (wr && paddr == `ABS_OFF_INTERVAL && !transfer_active_flag_ff)
                auto_interval_setting_ff <= pwdata[5:0];
            if (wr && paddr == `ABS_OFF_TRIGGER && pwdata[`ABS_TRIG_STOP])
                stop_req_ff <= 1'b1;
            // Buffer RAM writes with byte lanes, only when enabled
            if (wr && is_ram && en)
            begin
                if (pstrb[0])
                    ram_ff[{ram_idx, 1'b0}] <= pwdata[7:0];
                if (pstrb[1])
                    ram_ff[{ram_idx, 1'b1}] <= pwdata[15:8];
            end

            // Baud generator free-runs while shifting
            if (!shifting)
            begin
                pre_cnt_ff <= 8'h00;
                div_cnt_ff <= 5'd0;
                sck_ff     <= 1'b1;
            end
            else if (pre_cnt_ff == BRG_PRESC[7:0] - 8'h01)
            begin
                pre_cnt_ff <= 8'h00;
                if (tick)
                begin
                    div_cnt_ff <= 5'd0;
                    sck_ff     <= ~sck_ff;
                end
                else
                    div_cnt_ff <= div_cnt_ff + 5'd1;
            end
            else
                pre_cnt_ff <= pre_cnt_ff + 8'h01;

            // Done flag: set by hardware wins over a clear
            if (wr && paddr == `ABS_OFF_STATUS && pwdata[`ABS_ST_DONE])
                done_ff <= 1'b0;

            // Transfer machine
            case (state_ff)
                ST_IDLE:
                begin
                    if (start_single && !transfer_active_flag_ff)
                    begin
                        serial_shift_byte_ff    <= pwdata[7:0];
                        sout_ff                 <= out_bit(pwdata[7:0], lsbf);
                        transfer_active_flag_ff <= 1'b1;
                        bit_cnt_ff              <= 3'd7;
                        state_ff                <= ST_SHIFT;
                    end
                    else if (start_auto)
                    begin
                        buffer_address_counter_ff <= 8'h00;
                        serial_shift_byte_ff    <= ram_ff[0];
                        sout_ff                 <= out_bit(ram_ff[0], lsbf);
                        transfer_active_flag_ff <= 1'b1;
                        stop_req_ff             <= 1'b0;
                        bit_cnt_ff              <= 3'd7;
                        state_ff                <= ST_SHIFT;
                    end
                end
                ST_SHIFT:
                begin
                    // Drive next bit on falling edge
                    if (do_drive && bit_cnt_ff != 3'd7)
                        sout_ff <= out_bit(serial_shift_byte_ff, lsbf);
                    // Sample on rising edge, shift in
                    if (do_sample)
                    begin
                        serial_shift_byte_ff <= rx_byte;
                        if (bit_cnt_ff == 3'd0)
                        begin
                            if (!auto_md)
                            begin
                                transfer_active_flag_ff <= 1'b0;
                                done_ff  <= 1'b1;
                                state_ff <= ST_IDLE;
                            end
                            else
                            begin
                                ram_ff[cur] <= rx_byte;
                                gap_cnt_ff  <= auto_interval_setting_ff;
                                state_ff    <= ST_GAP;
                            end
                        end
                        else
                            bit_cnt_ff <= bit_cnt_ff - 3'd1;
                    end
                end
                ST_GAP:
                begin
                    if (gap_cnt_ff != 6'd0)
                        gap_cnt_ff <= gap_cnt_ff - 6'd1;
                    else if (last_auto && !repeat_md)
                    begin
                        transfer_active_flag_ff <= 1'b0;
                        done_ff  <= 1'b1;
                        state_ff <= ST_IDLE;
                    end
                    else if (stop_req_ff)
                    begin
                        transfer_active_flag_ff <= 1'b0;
                        stop_req_ff <= 1'b0;
                        buffer_address_counter_ff <= {3'h0, cur + 5'd1};
                        state_ff <= ST_IDLE;
                    end
                    else
                    begin
                        if (last_auto)
                        begin
                            done_ff <= 1'b1;
                            buffer_address_counter_ff <= 8'h00;
                            serial_shift_byte_ff <= ram_ff[0];
                            sout_ff <= out_bit(ram_ff[0], lsbf);
                        end
                        else
                        begin
                            buffer_address_counter_ff <= {3'h0, cur + 5'd1};
                            serial_shift_byte_ff <= ram_ff[cur + 5'd1];
                            sout_ff <= out_bit(ram_ff[cur + 5'd1], lsbf);
                        end
                        bit_cnt_ff <= 3'd7;
                        state_ff   <= ST_SHIFT;
                    end
                end
                default:
                    state_ff <= ST_IDLE;
            endcase

            // Unit disable acts as local reset
            if (!en && !(wr && paddr == `ABS_OFF_MODE && pwdata[`ABS_MODE_ENABLE]))
            begin
                serial_shift_byte_ff      <= `ABS_RST_BYTE;
                buffer_address_counter_ff <= `ABS_RST_BYTE;
                transfer_active_flag_ff   <= 1'b0;
                stop_req_ff               <= 1'b0;
                sout_ff                   <= 1'b0;
                state_ff                  <= ST_IDLE;
            end
        end
    end

endmodule // abs_serial

// File: verilog/abs_defines.vh
// Purpose: Register offsets, field positions, reset values and timing constants
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Definitions only, no logic
`ifndef ABS_DEFINES_VH
`define ABS_DEFINES_VH

// ======================================================================
// Register byte offsets
`define ABS_OFF_MODE      12'h000
`define ABS_OFF_STATUS    12'h004
`define ABS_OFF_TRIGGER   12'h008
`define ABS_OFF_DIVISOR   12'h00c
`define ABS_OFF_ENDPTR    12'h010
`define ABS_OFF_INTERVAL  12'h014
`define ABS_OFF_SHIFT     12'h018
`define ABS_OFF_ADDRCNT   12'h01c
`define ABS_OFF_RAM_BASE  12'h040
`define ABS_OFF_RAM_LAST  12'h07c

// ======================================================================
// Mode control, trigger and status field positions
`define ABS_MODE_ENABLE   7
`define ABS_MODE_AUTO     6
`define ABS_MODE_REPEAT   5
`define ABS_MODE_MASTER   4
`define ABS_MODE_TXEN     3
`define ABS_MODE_RXEN     2
`define ABS_MODE_LSBF     1
`define ABS_TRIG_START    0
`define ABS_TRIG_STOP     1
`define ABS_ST_ACTIVE     0
`define ABS_ST_DONE       1

// ======================================================================
// Reset values
`define ABS_RST_BYTE      8'h00

// ======================================================================
// Timing
`define ABS_CLK_MHZ       250
`define ABS_MAX_KBPS      2000
`define ABS_BRG_PRESC     (((`ABS_CLK_MHZ * 1000) / (`ABS_MAX_KBPS * 32)) + 1)

`endif

// File: tb/abs_serial_chk.sv
// Purpose: Port-level assertions for abs_serial
// Assumes: Mode writes carry the whole byte in pwdata[7:0]
// Notes:   Mode control is shadowed from observed APB writes
`timescale 1ns/100ps
`include "abs_defines.vh"
module abs_serial_chk
(
    // Clock, reset and APB
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    // Serial pins and interrupt
    input wire        serial_clock_pin_o,
    input wire        serial_clock_pin_oe_n,
    input wire        serial_out_pin,
    input wire        transfer_done_irq
);
    // ==========================================================
    // Shadow of mode control
    wire       mode_wr = psel && penable && pwrite && (paddr == `ABS_OFF_MODE);
    reg  [7:0] mode_ff;  // Last mode byte written
    always @(posedge pclk or negedge presetn)
        if (!presetn)
            mode_ff <= 8'h00;
        else if (mode_wr)
            mode_ff <= pwdata[7:0];
    // ==========================================================
    // Assertions
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_irq_reset: assert property ($rose(presetn) |-> !transfer_done_irq)
        else $error("done interrupt high after reset");
    chk_clk_reset: assert property ($rose(presetn) |-> serial_clock_pin_o)
        else $error("serial clock not high after reset");
    chk_out_reset: assert property ($rose(presetn) |-> !serial_out_pin)
        else $error("serial out not low after reset");
    chk_disable_idle: assert property (mode_wr && !pwdata[7] |-> ##2
        serial_clock_pin_o && !serial_out_pin)
        else $error("pins not parked after disable");
    chk_half_period: assert property ($fell(serial_clock_pin_o) |=>
        (!serial_clock_pin_o) [*2])
        else $error("serial clock low phase too short");
    chk_txdis_low: assert property ((!mode_ff[3]) [*3] |-> !serial_out_pin)
        else $error("serial out driven with transmit off");
    chk_oe_drive: assert property ((!mode_ff[7] || mode_ff[4]) [*3] |->
        !serial_clock_pin_oe_n)
        else $error("clock pin not driven in master or disabled");
    chk_irq_idle: assert property ($rose(transfer_done_irq) |-> serial_clock_pin_o)
        else $error("done raised with clock not idle");
endmodule // abs_serial_chk

bind abs_serial abs_serial_chk abs_serial_chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .serial_clock_pin_o(serial_clock_pin_o), .serial_clock_pin_oe_n(serial_clock_pin_oe_n),
    .serial_out_pin(serial_out_pin), .transfer_done_irq(transfer_done_irq));

// File: tb/abs_peer.sv
// Purpose: Serial peripheral on the far side of the link
// Assumes: Clock idles high, data changes on falling edge
// Notes:   Sends tx_byte MSB first each frame, keeps last byte seen
`timescale 1ns/100ps
module abs_peer
(
    // Serial lines
    input  wire        sclk,
    input  wire        sdo,
    output reg         sdi,
    // Bench side
    input  wire        rst_n,
    input  wire [7:0]  tx_byte,
    output reg  [7:0]  rx_byte,
    output reg  [31:0] frames
);
    reg [7:0] tx_sr, rx_sr, src;  // Shifters and next source
    reg [2:0] cnt;                // Bit position in frame
    initial
    begin
        sdi = 1'b0;
        rx_byte = 8'h00;
        frames = 32'h0;
        cnt = 3'd0;
        tx_sr = 8'h00;
        rx_sr = 8'h00;
    end
    // Present next bit; a new byte is loaded at frame start
    always @(negedge sclk)
    begin
        src = (cnt == 3'd0) ? tx_byte : tx_sr;
        sdi <= src[7];
        tx_sr <= {src[6:0], 1'b0};
    end
    // Sample; 20 ns after the eighth bit the line flips, so stale data never passes
    always @(posedge sclk)
        if (rst_n)
        begin
            rx_sr = {rx_sr[6:0], sdo};
            cnt <= cnt + 3'd1;
            if (cnt == 3'd7)
            begin
                rx_byte <= rx_sr;
                frames <= frames + 32'd1;
                sdi <= #20 ~sdi;
            end
        end
endmodule // abs_peer

// File: tb/abs_serial_tb.sv
// Purpose: Self-checking bench for abs_serial over APB
// Assumes: BRG_PRESC 1, so half periods are 3/4/8/16 pclk
// Notes:   In the slave scenario the bench drives the link clock
`timescale 1ns/100ps
`include "abs_defines.vh"
module abs_serial_tb;
    // ==========================================================
    // Signals
    reg         pclk, presetn, psel, penable, pwrite, irq_q, slv_sck;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    reg  [3:0]  pstrb;
    reg  [7:0]  peer_tx;
    wire [31:0] prdata, peer_frames;
    wire [7:0]  peer_rx;
    wire        pready, pslverr, sck_o, sck_oe_n, sdo, sdi, irq;
    integer     mismatches, checked, cycles, irq_rises, i, n, f0, r0;

    abs_serial #(.RAM_BYTES(32), .BRG_PRESC(1)) abs_serial_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_clock_pin_i(slv_sck),
        .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_n(sck_oe_n),
        .serial_in_pin(sdi), .serial_out_pin(sdo), .transfer_done_irq(irq));
    abs_peer abs_peer_i (.sclk(sck_oe_n ? slv_sck : sck_o), .sdo(sdo), .sdi(sdi), .rst_n(presetn),
        .tx_byte(peer_tx), .rx_byte(peer_rx), .frames(peer_frames));

    // ==========================================================
    // Clock, cycle limit, done-interrupt rising edges
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cycles = cycles + 1;
        irq_q <= irq;
        if (irq === 1'b1 && irq_q === 1'b0)
            irq_rises = irq_rises + 1;
        if (cycles == 20000)
        begin
            mismatches = mismatches + 1;
            final_report;
        end
    end

    // ==========================================================
    // APB transfer; read data lands in rd at the completing edge
    task apb(input [11:0] a, input w, input [31:0] d, input [3:0] s);
    begin
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        check("pslverr", 32'h0, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    task check(input [127:0] what, input [31:0] exp, input [31:0] got);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0s expected %h seen %h", what, exp, got);
        end
    end
    endtask
    // Poll a status bit; the cycle limit cuts a hang
    task wait_bit(input integer b, input v);
    begin
        rd = {32{~v}};
        while (rd[b] !== v)
            apb(`ABS_OFF_STATUS, 1'b0, 32'h0, 4'h0);
    end
    endtask
    function [7:0] rev8(input [7:0] b);
        integer k;
    begin
        for (k = 0; k < 8; k = k + 1)
            rev8[k] = b[7 - k];
    end
    endfunction
    task final_report;
    begin
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, irq_q, slv_sck} = 6'h1;
        {paddr, pwdata, pstrb, peer_tx} = 56'h0;
        {mismatches, checked, cycles, irq_rises} = 128'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(`ABS_OFF_SHIFT, 1'b0, 32'h0, 4'h0);
        check("shift reset", 32'h0, rd);
        apb(`ABS_OFF_ADDRCNT, 1'b0, 32'h0, 4'h0);
        check("addrcnt reset", 32'h0, rd);
        apb(`ABS_OFF_STATUS, 1'b0, 32'h0, 4'h0);
        check("status reset", 32'h0, rd);
        apb(12'h020, 1'b0, 32'h0, 4'h0);
        check("unmapped", 32'h0, rd);
        peer_tx <= 8'hc1;
        // One byte per divisor; the last one LSB first
        for (i = 0; i < 4; i = i + 1)
        begin
            apb(`ABS_OFF_DIVISOR, 1'b1, i, 4'hf);
            apb(`ABS_OFF_MODE, 1'b1, (i == 3) ? 32'h9e : 32'h9c, 4'hf);
            apb(`ABS_OFF_SHIFT, 1'b1, 32'h30 + i, 4'hf);
            n = 0;
            while (sck_o !== 1'b0)
                @(posedge pclk) #1;
            while (sck_o === 1'b0)
            begin
                @(posedge pclk) #1;
                n = n + 1;
            end
            check("half period", (i == 0) ? 3 : (i == 1) ? 4 : (i == 2) ? 8 : 16, n);
            wait_bit(`ABS_ST_DONE, 1'b1);
            check("active", 32'h0, {31'h0, rd[0]});
            check("irq", 32'h1, {31'h0, irq});
            check("peer rx", (i == 3) ? rev8(8'h30 + i[7:0]) : 8'h30 + i[7:0], peer_rx);
            apb(`ABS_OFF_SHIFT, 1'b0, 32'h0, 4'h0);
            check("shift rx", (i == 3) ? rev8(8'hc1) : 8'hc1, rd);
            apb(`ABS_OFF_STATUS, 1'b1, 32'h2, 4'hf);
        end
        // Transmit off: a dummy write still runs a frame
        apb(`ABS_OFF_MODE, 1'b1, 32'h94, 4'hf);
        apb(`ABS_OFF_SHIFT, 1'b1, 32'hff, 4'hf);
        wait_bit(`ABS_ST_DONE, 1'b1);
        check("tx off out", 32'h0, peer_rx);
        apb(`ABS_OFF_SHIFT, 1'b0, 32'h0, 4'h0);
        check("tx off rx", 32'hc1, rd);
        apb(`ABS_OFF_STATUS, 1'b1, 32'h2, 4'hf);
        // Slave: bench clocks the link, six pclk per half period
        apb(`ABS_OFF_MODE, 1'b1, 32'h8c, 4'hf);
        apb(`ABS_OFF_SHIFT, 1'b1, 32'h6b, 4'hf);
        repeat (16)
        begin
            repeat (6) @(posedge pclk);
            slv_sck <= ~slv_sck;
        end
        wait_bit(`ABS_ST_DONE, 1'b1);
        check("slave tx", 32'h6b, peer_rx);
        apb(`ABS_OFF_SHIFT, 1'b0, 32'h0, 4'h0);
        check("slave rx", 32'hc1, rd);
        apb(`ABS_OFF_STATUS, 1'b1, 32'h2, 4'hf);
        // Auto single run of four bytes with a gap
        peer_tx <= 8'h5a;
        apb(12'h040, 1'b1, 32'h2211, 4'h3);
        apb(12'h044, 1'b1, 32'h4433, 4'h3);
        apb(`ABS_OFF_ENDPTR, 1'b1, 32'h3, 4'hf);
        apb(`ABS_OFF_INTERVAL, 1'b1, 32'h5, 4'hf);
        apb(`ABS_OFF_MODE, 1'b1, 32'hdc, 4'hf);
        f0 = peer_frames;
        r0 = irq_rises;
        apb(`ABS_OFF_TRIGGER, 1'b1, 32'h1, 4'hf);
        wait_bit(`ABS_ST_DONE, 1'b1);
        check("auto frames", 32'h4, peer_frames - f0);
        check("auto last", 32'h44, peer_rx);
        check("auto irqs", 32'h1, irq_rises - r0);
        apb(`ABS_OFF_ADDRCNT, 1'b0, 32'h0, 4'h0);
        check("addrcnt end", 32'h3, rd);
        apb(12'h040, 1'b0, 32'h0, 4'h0);
        check("ram rx", 32'h5a5a, {16'h0, rd[15:0]});
        apb(`ABS_OFF_STATUS, 1'b1, 32'h2, 4'hf);
        // Repeat run: two completions, then stop
        apb(`ABS_OFF_MODE, 1'b1, 32'hfc, 4'hf);
        f0 = peer_frames;
        apb(`ABS_OFF_TRIGGER, 1'b1, 32'h1, 4'hf);
        wait_bit(`ABS_ST_DONE, 1'b1);
        apb(`ABS_OFF_STATUS, 1'b1, 32'h2, 4'hf);
        wait_bit(`ABS_ST_DONE, 1'b1);
        apb(`ABS_OFF_TRIGGER, 1'b1, 32'h2, 4'hf);
        wait_bit(`ABS_ST_ACTIVE, 1'b0);
        check("repeat frames", 32'h1, {31'h0, (peer_frames - f0 >= 8)});
        // Disable clears the unit and parks the pins
        apb(`ABS_OFF_MODE, 1'b1, 32'h0, 4'hf);
        apb(`ABS_OFF_SHIFT, 1'b0, 32'h0, 4'h0);
        check("shift off", 32'h0, rd);
        apb(12'h040, 1'b0, 32'h0, 4'h0);
        check("ram off", 32'h0, rd);
        #1;
        check("pins off", 32'h2, {30'h0, sck_o, sdo});
        final_report;
    end
endmodule // abs_serial_tb
